// ==== design/slm_consts.svh ====
/*
 Constants for the system lockup manager: register offsets, field
 positions, reset values and timing counts.
 Assumes it is included by bare name from design files.
*/
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH

// Register byte offsets
`define SLM_CTRL_OFF 12'h000
`define SLM_RELOAD_OFF 12'h004
`define SLM_COUNT_OFF 12'h008
`define SLM_STAT_OFF 12'h00C
`define SLM_MASK_OFF 12'h010
`define SLM_FDIS_OFF 12'h014
`define SLM_ROUTE_OFF 12'h018

// Control fields
`define SLM_CTRL_WDEN 0
`define SLM_CTRL_KICK 1
`define SLM_CTRL_INTR_MGMT 2
`define SLM_CTRL_FETCH_EN 3

// Status and mask fields
`define SLM_ST_WD1 0
`define SLM_ST_WD2 1
`define SLM_ST_ECC 2
`define SLM_ST_INTR 3
`define SLM_ST_NOFETCH 4
`define SLM_ST_W 5

// Reset values
`define SLM_CTRL_RST 32'h0000_0008
`define SLM_RELOAD_RST 32'h0000_FFFF
`define SLM_MASK_RST 32'h0000_0000
`define SLM_FDIS_RST 32'h0000_0000

// Timing
`define SLM_CLK_MHZ 125
`define SLM_FETCH_US 1000
`define SLM_FETCH_CYC (`SLM_FETCH_US * `SLM_CLK_MHZ)
`define SLM_RESET_PULSE 16

`endif

// ==== design/slm_fn_gate.sv ====
/*
 Gates decode and event lines of disabled on-chip functions.
 Assumes one enable bit per function, high means disabled.
*/
`timescale 1ns/1ps
module slm_fn_gate (
   input wire logic [8:0] fn_dis, // Disable per function
   input wire logic [8:0] dec_in, // Decode hits from functions
   input wire logic [8:0] irq_in, // Interrupt requests
   input wire logic [8:0] pme_in, // Power events
   output logic [8:0] dec_out, // Gated decode hits
   output logic [8:0] irq_out, // Gated interrupts
   output logic [8:0] pme_out // Gated power events
);
   // Mask all three groups by the disable bits
   always_comb begin
      dec_out = dec_in & ~fn_dis;
      irq_out = irq_in & ~fn_dis;
      pme_out = pme_in & ~fn_dis;
   end
endmodule : slm_fn_gate

// ==== design/slm_pkg.sv ====
/*
 Types shared by the system lockup manager modules.
 Assumes slm_consts.svh is available for constants.
*/
package slm_pkg;
   typedef enum logic [1:0] {
      WD_IDLE = 2'b00,
      WD_FIRST = 2'b01,
      WD_SECOND = 2'b10
   } slm_wd_t;

   typedef enum logic [1:0] {
      ECC_NONE = 2'b00,
      ECC_SYSM = 2'b01,
      ECC_NMI = 2'b10,
      ECC_SERR = 2'b11
   } slm_ecc_t;
endpackage : slm_pkg

// ==== design/slm_sync.sv ====
/*
 Two flip-flop synchroniser for pin inputs.
 Assumes the input is asynchronous to CLOCK; reset is synchronous.
*/
`timescale 1ns/1ps
module slm_sync (
   input wire logic clk, // Clock
   input wire logic rst_n, // Synchronous reset, low
   input wire logic rst_val, // Value held in reset
   input wire logic din, // Asynchronous input
   output logic dout // Synchronised output
);
   typedef struct packed {
      logic s1;
      logic s2;
   } slm_sync_t;
   slm_sync_t st_q, st_d;

   // Shift through two stages
   always_comb begin
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end

   // Register the stages; reset to the idle level so no false edge follows
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q.s1 <= rst_val;
         st_q.s2 <= rst_val;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.s2; // Only the second stage is read
endmodule : slm_sync

// ==== design/slm_top.sv ====
/*
 System lockup manager: two-stage watchdog, first-fetch check, ECC
 message routing, case intrusion and function disable, with an
 AXI4-Lite register slave.
 Assumes a single 125 MHz clock; INTRUDER_N and FETCH_SEEN are pins.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "slm_consts.svh"

module slm_top #(
   parameter int FETCH_CYCLES = `SLM_FETCH_CYC
) (
   input wire logic CLOCK, // 125 MHz clock
   input wire logic RESET_N, // Synchronous reset, low
   input wire logic [11:0] S_AXI_AWADDR, // Write address
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Write strobes
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   output logic [1:0] S_AXI_BRESP, // Write response
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic [11:0] S_AXI_ARADDR, // Read address
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output logic [1:0] S_AXI_RRESP, // Read response
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   input wire logic INTRUDER_N, // Case switch, active low pin
   input wire logic FETCH_SEEN, // First fetch seen, pin
   input wire logic ECC_MSG_VALID, // ECC message strobe, same clock
   input wire logic [1:0] ECC_MSG_KIND, // ECC message routing
   input wire logic [8:0] FN_DEC_IN, // Function decode hits
   input wire logic [8:0] FN_IRQ_IN, // Function interrupts
   input wire logic [8:0] FN_PME_IN, // Function power events
   output logic [8:0] FN_DEC_OUT, // Gated decode hits
   output logic [8:0] FN_IRQ_OUT, // Gated interrupts
   output logic [8:0] FN_PME_OUT, // Gated power events
   output logic SYSTEM_MGMT_IRQ_N, // System management irq, low
   output logic MGMT_TIMEOUT_IRQ, // Management timeout irq
   output logic NMI, // Non-maskable interrupt
   output logic SERR_N, // System error, low
   output logic SYS_RESET_N, // System reset request, low
   output logic IRQ // Register interrupt, high
);
   typedef struct packed {
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
      logic [31:0] reload;
      logic [31:0] count;
      slm_pkg::slm_wd_t wd;
      logic [`SLM_ST_W-1:0] stat;
      logic [`SLM_ST_W-1:0] mask;
      logic [8:0] fdis;
      logic [31:0] fetch_cnt;
      logic fetch_wait;
      logic [4:0] rst_cnt;
      logic sysm_p;
      logic mto_p;
      logic nmi_p;
      logic serr_p;
      logic intr_prev;
   } slm_state_t;

   slm_state_t st_q, st_d;
   logic intr_act_n;
   logic fetch_s;
   logic wr_go;
   logic rd_go;

   // Byte-lane merge of write data into a register
   function automatic logic [31:0] slm_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : slm_merge

   // Address is one of the mapped words
   function automatic logic slm_mapped(input logic [11:0] a);
      return (a == `SLM_CTRL_OFF) || (a == `SLM_RELOAD_OFF) ||
         (a == `SLM_COUNT_OFF) || (a == `SLM_STAT_OFF) ||
         (a == `SLM_MASK_OFF) || (a == `SLM_FDIS_OFF);
   endfunction : slm_mapped

   // Synchronise the pin inputs
   slm_sync u_intr_sync (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .rst_val(1'b1),
      .din(INTRUDER_N),
      .dout(intr_act_n)
   );
   slm_sync u_fetch_sync (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .rst_val(1'b0),
      .din(FETCH_SEEN),
      .dout(fetch_s)
   );

   // Function disable gating
   slm_fn_gate u_gate (
      .fn_dis(st_q.fdis),
      .dec_in(FN_DEC_IN),
      .irq_in(FN_IRQ_IN),
      .pme_in(FN_PME_IN),
      .dec_out(FN_DEC_OUT),
      .irq_out(FN_IRQ_OUT),
      .pme_out(FN_PME_OUT)
   );

   assign wr_go = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
   assign rd_go = S_AXI_ARVALID & ~st_q.rvalid;

   // Next state of bus, registers and event logic
   always_comb begin
      logic kick;
      logic wd_exp;
      logic intr_rise;
      logic [`SLM_ST_W-1:0] set;
      logic [31:0] mrg;
      kick = 1'b0;
      wd_exp = 1'b0;
      intr_rise = 1'b0;
      set = '0;
      mrg = 32'h0000_0000;
      st_d = st_q;
      st_d.sysm_p = 1'b0;
      st_d.mto_p = 1'b0;
      st_d.nmi_p = 1'b0;
      st_d.serr_p = 1'b0;
      st_d.ctrl[`SLM_CTRL_KICK] = 1'b0;

      // Capture write address and data in either order
      if (S_AXI_AWVALID && !st_q.aw_got) begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !st_q.w_got) begin
         st_d.w_got = 1'b1;
         st_d.w_data = S_AXI_WDATA;
         st_d.w_strb = S_AXI_WSTRB;
      end
      if (st_q.bvalid && S_AXI_BREADY) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && S_AXI_RREADY) begin
         st_d.rvalid = 1'b0;
      end

      // Register write decode
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = slm_mapped(st_q.aw_addr) ? 2'b00 : 2'b10;
         if (st_q.aw_addr == `SLM_CTRL_OFF) begin
            st_d.ctrl = slm_merge(st_q.ctrl, st_q.w_data, st_q.w_strb);
            kick = st_d.ctrl[`SLM_CTRL_KICK];
            st_d.ctrl[`SLM_CTRL_KICK] = 1'b0;
         end else if (st_q.aw_addr == `SLM_RELOAD_OFF) begin
            st_d.reload = slm_merge(st_q.reload, st_q.w_data,
               st_q.w_strb);
         end else if (st_q.aw_addr == `SLM_MASK_OFF) begin
            mrg = slm_merge({27'h000_0000, st_q.mask}, st_q.w_data,
               st_q.w_strb);
            st_d.mask = mrg[`SLM_ST_W-1:0];
         end else if (st_q.aw_addr == `SLM_FDIS_OFF) begin
            mrg = slm_merge({23'h00_0000, st_q.fdis}, st_q.w_data,
               st_q.w_strb);
            st_d.fdis = mrg[8:0];
         end
      end

      // Register read decode; status clears on read
      if (rd_go) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = 2'b00;
         st_d.rdata = 32'h0000_0000;
         if (S_AXI_ARADDR == `SLM_CTRL_OFF) begin
            st_d.rdata = st_q.ctrl;
         end else if (S_AXI_ARADDR == `SLM_RELOAD_OFF) begin
            st_d.rdata = st_q.reload;
         end else if (S_AXI_ARADDR == `SLM_COUNT_OFF) begin
            st_d.rdata = st_q.count;
         end else if (S_AXI_ARADDR == `SLM_STAT_OFF) begin
            st_d.rdata = {27'h000_0000, st_q.stat};
            st_d.stat = '0;
         end else if (S_AXI_ARADDR == `SLM_MASK_OFF) begin
            st_d.rdata = {27'h000_0000, st_q.mask};
         end else if (S_AXI_ARADDR == `SLM_FDIS_OFF) begin
            st_d.rdata = {23'h00_0000, st_q.fdis};
         end else begin
            st_d.rresp = 2'b10;
         end
      end

      // Two-stage watchdog
      if (!st_q.ctrl[`SLM_CTRL_WDEN] || kick) begin
         st_d.count = st_q.reload;
         st_d.wd = slm_pkg::WD_IDLE;
      end else if (st_q.count == 32'h0000_0000) begin
         wd_exp = 1'b1;
         st_d.count = st_q.reload;
         if (st_q.wd == slm_pkg::WD_IDLE) begin
            st_d.wd = slm_pkg::WD_FIRST;
            st_d.sysm_p = 1'b1;
            set[`SLM_ST_WD1] = 1'b1;
         end else begin
            st_d.wd = slm_pkg::WD_SECOND;
            st_d.rst_cnt = 5'(`SLM_RESET_PULSE);
            set[`SLM_ST_WD2] = 1'b1;
         end
      end else begin
         st_d.count = st_q.count - 32'h0000_0001;
      end

      // First fetch check after reset
      if (st_q.fetch_wait) begin
         if (fetch_s || !st_q.ctrl[`SLM_CTRL_FETCH_EN]) begin
            st_d.fetch_wait = 1'b0;
         end else if (st_q.fetch_cnt == 32'(FETCH_CYCLES - 1)) begin
            st_d.fetch_wait = 1'b0;
            st_d.rst_cnt = 5'(`SLM_RESET_PULSE);
            set[`SLM_ST_NOFETCH] = 1'b1;
         end else begin
            st_d.fetch_cnt = st_q.fetch_cnt + 32'h0000_0001;
         end
      end

      // ECC message routing
      if (ECC_MSG_VALID) begin
         set[`SLM_ST_ECC] = 1'b1;
         case (slm_pkg::slm_ecc_t'(ECC_MSG_KIND))
            slm_pkg::ECC_NONE: st_d.mto_p = 1'b1;
            slm_pkg::ECC_SYSM: st_d.sysm_p = 1'b1;
            slm_pkg::ECC_NMI: st_d.nmi_p = 1'b1;
            default: st_d.serr_p = 1'b1;
         endcase
      end

      // Intrusion: active low pin, event on assertion
      st_d.intr_prev = ~intr_act_n;
      intr_rise = ~intr_act_n & ~st_q.intr_prev;
      if (intr_rise) begin
         set[`SLM_ST_INTR] = 1'b1;
         if (st_q.ctrl[`SLM_CTRL_INTR_MGMT]) begin
            st_d.mto_p = 1'b1;
         end else begin
            st_d.sysm_p = 1'b1;
         end
      end

      // Reset pulse countdown
      if (st_q.rst_cnt != 5'h00 && st_d.rst_cnt == st_q.rst_cnt) begin
         st_d.rst_cnt = st_q.rst_cnt - 5'h01;
      end

      // Sticky status: set wins over read clear
      st_d.stat = st_d.stat | set;
      if (wd_exp) begin
         st_d.stat = st_d.stat | set;
      end
   end

   // Register all state
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         st_q <= '0;
         st_q.ctrl <= `SLM_CTRL_RST;
         st_q.reload <= `SLM_RELOAD_RST;
         st_q.count <= `SLM_RELOAD_RST;
         st_q.mask <= 5'(`SLM_MASK_RST);
         st_q.fdis <= 9'(`SLM_FDIS_RST);
         st_q.fetch_wait <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Bus and interrupt outputs
   assign S_AXI_AWREADY = ~st_q.aw_got;
   assign S_AXI_WREADY = ~st_q.w_got;
   assign S_AXI_BVALID = st_q.bvalid;
   assign S_AXI_BRESP = st_q.bresp;
   assign S_AXI_ARREADY = ~st_q.rvalid;
   assign S_AXI_RVALID = st_q.rvalid;
   assign S_AXI_RDATA = st_q.rdata;
   assign S_AXI_RRESP = st_q.rresp;
   assign SYSTEM_MGMT_IRQ_N = ~st_q.sysm_p;
   assign MGMT_TIMEOUT_IRQ = st_q.mto_p;
   assign NMI = st_q.nmi_p;
   assign SERR_N = ~st_q.serr_p;
   assign SYS_RESET_N = (st_q.rst_cnt == 5'h00);
   assign IRQ = |(st_q.stat & st_q.mask);

   // Second expiry follows the first by reload plus one cycles
   chk_wd_second_reset: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (st_q.wd == slm_pkg::WD_FIRST && st_q.count == 32'h0000_0000 &&
       st_q.ctrl[`SLM_CTRL_WDEN] && !wr_go) |=> !SYS_RESET_N)
      else $error("second expiry gave no reset");
   chk_wd_first_irq: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (st_q.wd == slm_pkg::WD_IDLE && st_q.count == 32'h0000_0000 &&
       st_q.ctrl[`SLM_CTRL_WDEN] && !wr_go) |=>
      (!SYSTEM_MGMT_IRQ_N && st_q.wd == slm_pkg::WD_FIRST))
      else $error("first expiry gave no mgmt irq");
   chk_wd_reload: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (st_q.wd == slm_pkg::WD_IDLE && st_q.count == 32'h0000_0000 &&
       st_q.ctrl[`SLM_CTRL_WDEN] && !wr_go) |=>
      (st_q.count == $past(st_q.reload)))
      else $error("watchdog did not reload");
   chk_fetch_reboot: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      $rose(st_q.stat[`SLM_ST_NOFETCH]) |-> !SYS_RESET_N)
      else $error("missing fetch gave no reboot");
   chk_ecc_nmi: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (ECC_MSG_VALID && ECC_MSG_KIND == 2'b10) |=> NMI)
      else $error("ecc message gave no nmi");
   chk_ecc_serr: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (ECC_MSG_VALID && ECC_MSG_KIND == 2'b11) |=> !SERR_N)
      else $error("ecc message gave no serr");
   chk_fn_decode: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      (FN_DEC_OUT & st_q.fdis) == 9'h000)
      else $error("disabled function decoded");
   chk_fn_events: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      ((FN_IRQ_OUT | FN_PME_OUT) & st_q.fdis) == 9'h000)
      else $error("disabled function raised event");
   chk_intr_route: assert property (@(posedge CLOCK)
      disable iff (!RESET_N)
      $rose(st_q.stat[`SLM_ST_INTR]) |->
      ($past(st_q.ctrl[`SLM_CTRL_INTR_MGMT]) ? MGMT_TIMEOUT_IRQ :
       !SYSTEM_MGMT_IRQ_N))
      else $error("intrusion routed wrongly");
endmodule : slm_top

// ==== tb/slm_host_model.sv ====
/*
 Host-side partner: processor first-fetch indication and memory
 controller ECC messages.
 Assumes the bench calls its tasks; one clock shared with the block.
*/
`timescale 1ns/1ps
module slm_host_model (
   input wire logic clk, // Clock
   output logic fetch_seen, // First fetch seen
   output logic ecc_valid, // ECC message strobe
   output logic [1:0] ecc_kind // ECC message routing
);
   // Idle: no fetch yet, no message
   initial begin
      fetch_seen = 1'b0;
      ecc_valid = 1'b0;
      ecc_kind = 2'b00;
   end

   // Processor fetches its first instruction
   task fetch_now();
      @(posedge clk);
      fetch_seen <= 1'b1;
   endtask : fetch_now

   // One-cycle message; kind scrambled once released
   task send_ecc(input logic [1:0] kind);
      @(posedge clk);
      ecc_valid <= 1'b1;
      ecc_kind <= kind;
      @(posedge clk);
      ecc_valid <= 1'b0;
      ecc_kind <= ~kind;
   endtask : send_ecc
endmodule : slm_host_model

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the system lockup manager.
 Assumes AXI4-Lite register access and the host model beside it.
*/
`timescale 1ns/1ps
`include "slm_consts.svh"
module testbench;
   localparam int FC = 50;
   logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, intruder_n;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [8:0] fn_in, dec_o, irq_o, pme_o;
   logic sm_irq_n, tmo, nmi, serr_n, sysrst_n, irq, fetch, eccv;
   logic [1:0] ecck;
   int fails, n_checks, cyc, lo_run, last_run, n_rst, br;
   int cnt [4];
   int b [4];

   slm_top #(.FETCH_CYCLES(FC)) dut (
      .CLOCK(clock), .RESET_N(reset_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .INTRUDER_N(intruder_n), .FETCH_SEEN(fetch),
      .ECC_MSG_VALID(eccv), .ECC_MSG_KIND(ecck),
      .FN_DEC_IN(fn_in), .FN_IRQ_IN(fn_in), .FN_PME_IN(fn_in),
      .FN_DEC_OUT(dec_o), .FN_IRQ_OUT(irq_o), .FN_PME_OUT(pme_o),
      .SYSTEM_MGMT_IRQ_N(sm_irq_n), .MGMT_TIMEOUT_IRQ(tmo), .NMI(nmi),
      .SERR_N(serr_n), .SYS_RESET_N(sysrst_n), .IRQ(irq));

   slm_host_model host (.clk(clock), .fetch_seen(fetch),
      .ecc_valid(eccv), .ecc_kind(ecck));

   // Clock, 8 ns period
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Count event pulses by kind and reset pulses with their length
   always @(posedge clock) begin
      cyc++;
      if (tmo === 1'b1) cnt[0]++;
      if (sm_irq_n === 1'b0) cnt[1]++;
      if (nmi === 1'b1) cnt[2]++;
      if (serr_n === 1'b0) cnt[3]++;
      if (sysrst_n === 1'b0) begin
         if (lo_run == 0) n_rst++;
         lo_run++;
      end else begin
         if (lo_run != 0) last_run = lo_run;
         lo_run = 0;
      end
      if (cyc == 5000) begin
         fails++;
         report_and_stop();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Expect exactly one pulse of kind k since the snapshot (k<0: none)
   task snap();
      b = cnt;
      br = n_rst;
   endtask : snap
   task delta(input int k);
      for (int i = 0; i < 4; i++) begin
         chk("pulse count", b[i] + (i == k), cnt[i]);
      end
   endtask : delta

   // AXI4-Lite write: address and data offered together
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   // AXI4-Lite read: data and response land in d and r
   task rd(input logic [11:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      reset_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      intruder_n = 1'b1;
      fn_in = 9'h1FF;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      // No first fetch: reboot pulse
      repeat (FC + 30) @(posedge clock);
      chk("reboot", 1, n_rst);
      chk("reboot length", `SLM_RESET_PULSE, last_run);
      host.fetch_now();
      rd(`SLM_STAT_OFF);
      chk("no fetch flag", 1, d[`SLM_ST_NOFETCH]);
      chk("no false intrusion", 0, d[`SLM_ST_INTR]);
      rd(`SLM_CTRL_OFF);
      chk("ctrl reset", `SLM_CTRL_RST, d);
      rd(`SLM_RELOAD_OFF);
      chk("reload reset", `SLM_RELOAD_RST, d);
      rd(`SLM_MASK_OFF);
      chk("mask reset", `SLM_MASK_RST, d);
      rd(`SLM_FDIS_OFF);
      chk("fdis reset", `SLM_FDIS_RST, d);
      rd(12'h01C);
      chk("unmapped resp", 2'b10, r);
      chk("unmapped data", 0, d);
      wr(12'h01C, 32'h0000_0000);
      chk("unmapped wr resp", 2'b10, r);
      $display("test fetch and reset done");
      // Function disable gates decode, interrupts and events
      for (int i = 0; i < 2; i++) begin
         wr(`SLM_FDIS_OFF, i ? 32'h0000_00AA : 32'h0000_0155);
         chk("wr resp", 2'b00, r);
         @(posedge clock);
         chk("decode", i ? 9'h155 : 9'h0AA, dec_o);
         chk("irq", i ? 9'h155 : 9'h0AA, irq_o);
         chk("pme", i ? 9'h155 : 9'h0AA, pme_o);
      end
      $display("test function disable done");
      // ECC messages of every kind
      for (int k = 0; k < 4; k++) begin
         snap();
         host.send_ecc(2'(k));
         repeat (4) @(posedge clock);
         delta(k);
      end
      rd(`SLM_STAT_OFF);
      chk("ecc flag", 1, d[`SLM_ST_ECC]);
      chk("masked irq", 1'b0, irq);
      $display("test ecc done");
      // Intrusion routed each way, unmasked
      wr(`SLM_MASK_OFF, 32'h0000_0008);
      for (int rt = 0; rt < 2; rt++) begin
         wr(`SLM_CTRL_OFF, 32'h0000_0008 | (rt << 2));
         snap();
         intruder_n <= 1'b0;
         repeat (8) @(posedge clock);
         delta(1 - rt);
         chk("irq raised", 1'b1, irq);
         rd(`SLM_STAT_OFF);
         chk("intrusion flag", 1, d[`SLM_ST_INTR]);
         intruder_n <= 1'b1;
         repeat (3) @(posedge clock);
         chk("irq cleared", 1'b0, irq);
      end
      $display("test intrusion done");
      // Watchdog: kicked, then first and second expiry
      wr(`SLM_RELOAD_OFF, 32'h0000_0014);
      wr(`SLM_CTRL_OFF, 32'h0000_0009);
      snap();
      repeat (6) wr(`SLM_CTRL_OFF, 32'h0000_000B);
      delta(-1);
      snap();
      repeat (30) @(posedge clock);
      delta(1);
      chk("no early reset", br, n_rst);
      repeat (25) @(posedge clock);
      chk("second expiry", br + 1, n_rst);
      wr(`SLM_CTRL_OFF, 32'h0000_0008);
      repeat (20) @(posedge clock);
      chk("reset length", `SLM_RESET_PULSE, last_run);
      rd(`SLM_STAT_OFF);
      chk("expiry flags", 2'b11, d[1:0]);
      $display("test watchdog done");
      // Second reset with the processor fetching: no reboot
      snap();
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      repeat (FC + 30) @(posedge clock);
      chk("fetch seen no reboot", br, n_rst);
      chk("irq after reset", 1'b0, irq);
      $display("test second reset done");
      report_and_stop();
   end
endmodule : testbench
